// file: logic/mrcs_top.sv
// remote command state of a power meter on an instrument bus
// assumes active-high pin levels, apb master on sys_clk
//
// The implementer's own choices: the register addresses and register access over APB.
module mrcs_top #(
   parameter logic [4:0] BUS_ADDR_RST = mrcs_pkg::ADDR_RST
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // bus pins from controller
   input wire logic [7:0] bus_dio_i,
   input wire logic bus_atn_i,
   input wire logic bus_dav_i,
   input wire logic bus_ack_i,
   // bus pins to controller
   output logic [7:0] bus_dio_o,
   output logic bus_dio_oe,
   output logic bus_dav_o,
   output logic bus_dav_oe,
   output logic bus_rxack_o,
   // meter state
   output logic clear_init_pulse,
   output logic listener_addressed_flag,
   output logic meas_hold,
   output logic [1:0] active_mode,
   output logic [2:0] range_count
);
   // synchronised pins
   logic [7:0] dio_s;
   logic atn_s, dav_s, ack_s;

   mrcs_pin_sync #(.WIDTH(11)) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pin_i({bus_atn_i, bus_dav_i, bus_ack_i, bus_dio_i}),
      .level_o({atn_s, dav_s, ack_s, dio_s})
   );

   // state
   logic dav_prev_r, rxack_r, listen_r, talk_r, remote_r, hold_r, settle_r, tx_dav_r;
   logic [mrcs_pkg::CLR_CNT_W-1:0] clr_cnt_r;
   mrcs_pkg::mrcs_mode_t prog_mode_r, mode_r;
   logic [2:0] prog_range_r, range_r, auto_range_r;
   mrcs_pkg::mrcs_pos_t pos_r;
   mrcs_pkg::mrcs_seq_t seq_r;
   logic [7:0] tx_dio_r, stat_char_r;
   logic [4:0] addr_r;
   logic [31:0] prdata_r;

   // decoding helpers
   function automatic logic is_clear(input logic [6:0] c, input logic lstn);
      is_clear = (c == mrcs_pkg::CMD_DCL) || ((c == mrcs_pkg::CMD_SDC) && lstn);
   endfunction

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == mrcs_pkg::REG_CTRL) || (a == mrcs_pkg::REG_MEAS) ||
         (a == mrcs_pkg::REG_STATE);
   endfunction

   function automatic logic [3:0] digit_of(input logic [6:0] c);
      logic [6:0] d;
      d = c - mrcs_pkg::CH_DIGIT0;
      digit_of = d[3:0];
   endfunction

   // byte strobes
   logic byte_stb, cmd_stb, data_stb, clr_start, clr_busy, is_digit, own_listen, own_talk;
   logic trig_go, rem_enter, tx_done, tx_load, sending;
   logic [6:0] ch;
   logic [3:0] dig;
   logic [7:0] tx_char;

   assign byte_stb = dav_s && !dav_prev_r;
   assign cmd_stb = byte_stb && atn_s;
   assign data_stb = byte_stb && !atn_s && listen_r;
   assign ch = dio_s[6:0];
   assign clr_start = cmd_stb && is_clear(ch, listen_r);
   assign clr_busy = clr_start || (clr_cnt_r != '0);
   assign own_listen = (ch == {mrcs_pkg::CMD_LAG, addr_r});
   assign own_talk = (ch == {mrcs_pkg::CMD_TAG, addr_r});
   assign is_digit = (ch >= mrcs_pkg::CH_DIGIT0) && (ch <= mrcs_pkg::CH_DIGIT0 + 7'h09);
   assign dig = digit_of(ch);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dav_prev_r <= 1'b0;
         rxack_r <= 1'b0;
      end else begin
         dav_prev_r <= dav_s;
         rxack_r <= dav_s;
      end
   end

   // addressing
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         listen_r <= 1'b0;
      end else if (cmd_stb) begin
         if (own_listen) begin
            listen_r <= 1'b1;
         end else if (own_talk || ch == mrcs_pkg::CMD_UNL) begin
            listen_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         talk_r <= 1'b0;
      end else if (cmd_stb) begin
         if (own_talk) begin
            talk_r <= 1'b1;
         end else if (ch[6:5] == mrcs_pkg::CMD_TAG || ch == mrcs_pkg::CMD_UNT) begin
            talk_r <= 1'b0;
         end
      end
   end

   // power cycling alone returns to local
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         remote_r <= 1'b0;
      end else if (cmd_stb && own_listen) begin
         remote_r <= 1'b1;
      end
   end

   // clear pulse
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         clr_cnt_r <= '0;
      end else if (clr_start) begin
         clr_cnt_r <= mrcs_pkg::CLR_CNT_W'(mrcs_pkg::CLR_PULSE_CYC);
      end else if (clr_cnt_r != '0) begin
         clr_cnt_r <= clr_cnt_r - 1'b1;
      end
   end

   // programming string parser
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prog_mode_r <= mrcs_pkg::MODE_WATT;
         prog_range_r <= mrcs_pkg::RANGE_AUTO;
         pos_r <= mrcs_pkg::POS_IDLE;
      end else if (clr_start) begin
         prog_mode_r <= mrcs_pkg::MODE_WATT;
         prog_range_r <= mrcs_pkg::RANGE_AUTO;
         pos_r <= mrcs_pkg::POS_IDLE;
      end else if (data_stb) begin
         if (ch >= mrcs_pkg::CH_MODE_FIRST && ch <= mrcs_pkg::CH_MODE_LAST) begin
            prog_mode_r <= mrcs_pkg::mrcs_mode_t'(2'(ch - mrcs_pkg::CH_MODE_FIRST));
            pos_r <= mrcs_pkg::POS_RANGE;
         end else if (is_digit && pos_r == mrcs_pkg::POS_RANGE) begin
            if (dig == mrcs_pkg::RANGE_AUTO_CODE) begin
               prog_range_r <= mrcs_pkg::RANGE_AUTO;
            end else if (dig != 4'h0 && dig <= mrcs_pkg::RANGE_MAX_CODE) begin
               prog_range_r <= dig[2:0];
            end
            pos_r <= mrcs_pkg::POS_TRIG;
         end else begin
            pos_r <= mrcs_pkg::POS_IDLE;
         end
      end
   end

   assign trig_go = data_stb && is_digit && pos_r == mrcs_pkg::POS_TRIG &&
      (dig == mrcs_pkg::TRIG_IMM_CODE || dig == mrcs_pkg::TRIG_SETTLE_CODE);
   assign rem_enter = (seq_r == mrcs_pkg::SEQ_LR_WAIT) && !hold_r && remote_r && !clr_busy;

   // measurement hold, released only by a trigger
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_r <= 1'b1;
      end else if (clr_start) begin
         hold_r <= 1'b1;
      end else if (trig_go) begin
         hold_r <= 1'b0;
      end else if (data_stb && is_digit && pos_r == mrcs_pkg::POS_TRIG &&
                   dig == mrcs_pkg::TRIG_HOLD_CODE) begin
         hold_r <= 1'b1;
      end else if (rem_enter) begin
         hold_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_r <= 1'b0;
      end else if (clr_start) begin
         settle_r <= 1'b0;
      end else if (trig_go) begin
         settle_r <= (dig == mrcs_pkg::TRIG_SETTLE_CODE);
      end
   end

   // active mode and range counter
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= mrcs_pkg::MODE_WATT;
         range_r <= mrcs_pkg::RANGE_ARST;
      end else if (clr_start) begin
         mode_r <= mrcs_pkg::MODE_WATT;
         range_r <= auto_range_r;
      end else if (seq_r == mrcs_pkg::SEQ_REM_INIT) begin
         mode_r <= prog_mode_r;
         range_r <= (prog_range_r == mrcs_pkg::RANGE_AUTO) ? auto_range_r : prog_range_r;
      end
   end

   // sequencer
   assign tx_done = tx_dav_r && ack_s;
   assign sending = (seq_r == mrcs_pkg::SEQ_SEND_STAT) ||
      (seq_r == mrcs_pkg::SEQ_SEND_RANGE) || (seq_r == mrcs_pkg::SEQ_SEND_MODE);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         seq_r <= mrcs_pkg::SEQ_LR_WAIT;
      end else if (clr_busy) begin
         seq_r <= mrcs_pkg::SEQ_START;
      end else begin
         case (seq_r)
            mrcs_pkg::SEQ_START: begin
               seq_r <= mrcs_pkg::SEQ_LR_WAIT;
            end
            mrcs_pkg::SEQ_LR_WAIT: begin
               if (rem_enter) begin
                  seq_r <= mrcs_pkg::SEQ_REM_INIT;
               end
            end
            mrcs_pkg::SEQ_REM_INIT: begin
               seq_r <= mrcs_pkg::SEQ_TALK_WAIT;
            end
            mrcs_pkg::SEQ_TALK_WAIT: begin
               if (talk_r) begin
                  seq_r <= mrcs_pkg::SEQ_SEND_STAT;
               end
            end
            mrcs_pkg::SEQ_SEND_STAT: begin
               if (tx_done) begin
                  seq_r <= mrcs_pkg::SEQ_SEND_RANGE;
               end
            end
            mrcs_pkg::SEQ_SEND_RANGE: begin
               if (tx_done) begin
                  seq_r <= mrcs_pkg::SEQ_SEND_MODE;
               end
            end
            mrcs_pkg::SEQ_SEND_MODE: begin
               if (tx_done) begin
                  seq_r <= mrcs_pkg::SEQ_LR_WAIT;
               end
            end
            default: begin
               seq_r <= mrcs_pkg::SEQ_START;
            end
         endcase
      end
   end

   // talk characters
   always_comb begin
      case (seq_r)
         mrcs_pkg::SEQ_SEND_STAT: tx_char = stat_char_r;
         mrcs_pkg::SEQ_SEND_RANGE: tx_char = mrcs_pkg::RANGE_CHAR_BASE + {5'h00, range_r};
         mrcs_pkg::SEQ_SEND_MODE: tx_char = mrcs_pkg::MODE_CHAR_BASE + {6'h00, mode_r};
         default: tx_char = 8'h00;
      endcase
   end

   assign tx_load = sending && talk_r && !atn_s && !ack_s && !tx_dav_r;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_dav_r <= 1'b0;
         tx_dio_r <= 8'h00;
      end else if (clr_busy) begin
         tx_dav_r <= 1'b0;
      end else if (tx_done) begin
         tx_dav_r <= 1'b0;
      end else if (tx_load) begin
         tx_dav_r <= 1'b1;
         tx_dio_r <= tx_char;
      end
   end

   // apb registers
   logic wr_en, setup;
   logic [31:0] state_word;

   assign wr_en = psel && penable && pwrite;
   assign setup = psel && !penable;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_r <= BUS_ADDR_RST;
      end else if (wr_en && paddr == mrcs_pkg::REG_CTRL) begin
         addr_r <= pwdata[mrcs_pkg::CTRL_ADDR_LSB +: mrcs_pkg::ADDR_W];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_char_r <= mrcs_pkg::STAT_CHAR_RST;
         auto_range_r <= mrcs_pkg::RANGE_ARST;
      end else if (wr_en && paddr == mrcs_pkg::REG_MEAS) begin
         stat_char_r <= pwdata[mrcs_pkg::MEAS_STAT_LSB +: 8];
         auto_range_r <= pwdata[mrcs_pkg::MEAS_ARNG_LSB +: 3];
      end
   end

   always_comb begin
      state_word = 32'h0000_0000;
      state_word[mrcs_pkg::ST_LSTN] = listen_r;
      state_word[mrcs_pkg::ST_TALK] = talk_r;
      state_word[mrcs_pkg::ST_HOLD] = hold_r;
      state_word[mrcs_pkg::ST_REM] = remote_r;
      state_word[mrcs_pkg::ST_CLR] = (clr_cnt_r != '0);
      state_word[mrcs_pkg::ST_SETTLE] = settle_r;
      state_word[mrcs_pkg::ST_MODE_LSB +: 2] = mode_r;
      state_word[mrcs_pkg::ST_RANGE_LSB +: 3] = range_r;
      state_word[mrcs_pkg::ST_SEQ_LSB +: 7] = seq_r;
      state_word[mrcs_pkg::ST_PMODE_LSB +: 2] = prog_mode_r;
      state_word[mrcs_pkg::ST_PRANGE_LSB +: 3] = prog_range_r;
   end

   // read data captured in the setup cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup) begin
         case (paddr)
            mrcs_pkg::REG_CTRL: prdata_r <= {27'h0, addr_r};
            mrcs_pkg::REG_MEAS: prdata_r <= {21'h0, auto_range_r, stat_char_r};
            mrcs_pkg::REG_STATE: prdata_r <= state_word;
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_hit(paddr);

   // pins and state outputs
   assign bus_dio_o = tx_dio_r;
   assign bus_dav_o = tx_dav_r;
   assign bus_dio_oe = talk_r && !atn_s;
   assign bus_dav_oe = talk_r && !atn_s;
   assign bus_rxack_o = rxack_r;
   assign clear_init_pulse = (clr_cnt_r != '0);
   assign listener_addressed_flag = listen_r;
   assign meas_hold = hold_r;
   assign active_mode = mode_r;
   assign range_count = range_r;
endmodule

// file: pkg/mrcs_pkg.sv
// constants, types and register map of the meter remote command state block
// assumes one 20 MHz clock, an APB master and active-high bus pin levels
package mrcs_pkg;
   // apb map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MEAS = 8'h04;
   localparam logic [7:0] REG_STATE = 8'h08;
   // ctrl fields
   localparam int CTRL_ADDR_LSB = 0;
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_RST = 5'h0d;
   // meas fields
   localparam int MEAS_STAT_LSB = 0;
   localparam int MEAS_ARNG_LSB = 8;
   localparam logic [7:0] STAT_CHAR_RST = 8'h30;
   // state fields
   localparam int ST_LSTN = 0;
   localparam int ST_TALK = 1;
   localparam int ST_HOLD = 2;
   localparam int ST_REM = 3;
   localparam int ST_CLR = 4;
   localparam int ST_SETTLE = 5;
   localparam int ST_MODE_LSB = 6;
   localparam int ST_RANGE_LSB = 8;
   localparam int ST_SEQ_LSB = 16;
   localparam int ST_PMODE_LSB = 24;
   localparam int ST_PRANGE_LSB = 28;
   // bus commands, seven bit, sent with attention
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_UNL = 7'h3f;
   localparam logic [6:0] CMD_UNT = 7'h5f;
   localparam logic [1:0] CMD_LAG = 2'h1;
   localparam logic [1:0] CMD_TAG = 2'h2;
   // programming characters
   localparam logic [6:0] CH_MODE_FIRST = 7'h41;
   localparam logic [6:0] CH_MODE_LAST = 7'h44;
   localparam logic [6:0] CH_DIGIT0 = 7'h30;
   localparam logic [3:0] RANGE_MAX_CODE = 4'h5;
   localparam logic [3:0] RANGE_AUTO_CODE = 4'h9;
   localparam logic [3:0] TRIG_HOLD_CODE = 4'h0;
   localparam logic [3:0] TRIG_IMM_CODE = 4'h1;
   localparam logic [3:0] TRIG_SETTLE_CODE = 4'h2;
   // range counter, zero stands for auto
   localparam logic [2:0] RANGE_AUTO = 3'h0;
   localparam logic [2:0] RANGE_ARST = 3'h1;
   // output characters
   localparam logic [7:0] MODE_CHAR_BASE = 8'h41;
   localparam logic [7:0] RANGE_CHAR_BASE = 8'h30;
   // clear pulse length
   localparam int CLR_PULSE_NS = 200;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CLR_PULSE_CYC = (CLR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLR_CNT_W = 3;

   typedef enum logic [1:0] {
      MODE_WATT = 2'h0,
      MODE_DBM = 2'h1,
      MODE_DBREL = 2'h2,
      MODE_DBREF = 2'h3
   } mrcs_mode_t;

   typedef enum logic [1:0] {
      POS_IDLE = 2'h0,
      POS_RANGE = 2'h1,
      POS_TRIG = 2'h2
   } mrcs_pos_t;

   // start is sequencer address 000 (octal)
   typedef enum logic [6:0] {
      SEQ_START = 7'h01,
      SEQ_LR_WAIT = 7'h02,
      SEQ_REM_INIT = 7'h04,
      SEQ_TALK_WAIT = 7'h08,
      SEQ_SEND_STAT = 7'h10,
      SEQ_SEND_RANGE = 7'h20,
      SEQ_SEND_MODE = 7'h40
   } mrcs_seq_t;
endpackage

// file: logic/mrcs_pin_sync.sv
// three-stage synchroniser with agreement filter for bus pins
// assumes pins are asynchronous to sys_clk
module mrcs_pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // pins and filtered levels
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit changes once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               level_o[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
               level_o[i] <= s3_r[i];
            end
         end
      end
   endgenerate
endmodule

// file: testbench/mrcs_top_asserts.sv
// port checker of the meter remote command state block
// assumes one clock domain and an active-high asynchronous reset
module mrcs_top_asserts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // bus pins
   input wire logic bus_atn_i,
   input wire logic bus_dav_i,
   input wire logic bus_ack_i,
   input wire logic [7:0] bus_dio_o,
   input wire logic bus_dio_oe,
   input wire logic bus_dav_o,
   input wire logic bus_dav_oe,
   input wire logic bus_rxack_o,
   // meter state
   input wire logic clear_init_pulse,
   input wire logic listener_addressed_flag,
   input wire logic meas_hold
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_clr_rise;
      $rose(clear_init_pulse);
   endsequence
   sequence s_clr_body;
      clear_init_pulse [*4] ##1 !clear_init_pulse;
   endsequence
   sequence s_dav_held;
      bus_dav_o ##1 bus_dav_o;
   endsequence
   a_clear_width: assert property (s_clr_rise |-> s_clr_body)
      else $error("clear pulse length wrong");
   a_clear_holds: assert property (s_clr_rise |-> ##1 meas_hold [*3])
      else $error("hold not set by clear");
   a_clear_no_talk: assert property (s_clr_rise |-> ##1 (!bus_dav_o) [*3])
      else $error("talk during clear");
   a_clear_cause: assert property (s_clr_rise |-> $past(bus_atn_i, 2))
      else $error("clear without command byte");
   a_hold_release: assert property ($fell(meas_hold) |-> ##[0:2] bus_rxack_o)
      else $error("hold dropped without a byte");
   a_listen_cause: assert property ($changed(listener_addressed_flag) |-> ##[0:2] bus_rxack_o)
      else $error("listen state changed without a byte");
   a_talk_stable: assert property (s_dav_held |-> $stable(bus_dio_o))
      else $error("talk byte changed while valid");
   a_talk_drive: assert property ($rose(bus_dav_o) |-> bus_dio_oe && bus_dav_oe)
      else $error("talk byte not driven");
   a_talk_ack: assert property ($fell(bus_dav_o) && !clear_init_pulse |-> $past(bus_ack_i, 3))
      else $error("talk valid dropped without accept");
   a_rx_ack: assert property ($rose(bus_dav_i) |-> ##[3:8] bus_rxack_o)
      else $error("received byte not accepted");
   a_apb_err: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08})
      |-> pslverr && pready)
      else $error("unmapped access without error");
endmodule

bind mrcs_top mrcs_top_asserts i_mrcs_top_asserts (.sys_clk, .sys_rst, .paddr, .psel, .penable,
   .pready, .pslverr, .bus_atn_i, .bus_dav_i, .bus_ack_i, .bus_dio_o, .bus_dio_oe, .bus_dav_o,
   .bus_dav_oe, .bus_rxack_o, .clear_init_pulse, .listener_addressed_flag, .meas_hold);

// file: testbench/mrcs_ctrl_model.sv
// bus controller model: sends bytes by handshake, accepts talk bytes
// assumes the meter answers every byte with its accept line
module mrcs_ctrl_model (
   // clock
   input wire logic sys_clk,
   // lines to the meter
   output logic [7:0] bus_dio_i,
   output logic bus_atn_i,
   output logic bus_dav_i,
   output logic bus_ack_i,
   // lines from the meter
   input wire logic bus_rxack_o,
   input wire logic bus_dav_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int ack_wait = 0;
   initial begin
      bus_dio_i = 8'hff;
      bus_atn_i = 1'b0;
      bus_dav_i = 1'b0;
      bus_ack_i = 1'b0;
   end
   // data settles a cycle before valid, released lines show the inverse
   task automatic send_byte(input logic atn, input logic [7:0] b);
      @(posedge sys_clk);
      bus_dio_i <= b;
      bus_atn_i <= atn;
      @(posedge sys_clk);
      bus_dav_i <= 1'b1;
      for (int i = 0; i < 100 && bus_rxack_o !== 1'b1; i++) @(posedge sys_clk);
      bus_dav_i <= 1'b0;
      for (int i = 0; i < 100 && bus_rxack_o !== 1'b0; i++) @(posedge sys_clk);
      bus_dio_i <= ~b;
      bus_atn_i <= 1'b0;
   endtask
   // accept talk bytes, optionally late
   always @(posedge sys_clk) begin
      if (bus_dav_o === 1'b1 && !bus_ack_i) begin
         repeat (ack_wait) @(posedge sys_clk);
         bus_ack_i <= 1'b1;
      end else if (bus_dav_o !== 1'b1)
         bus_ack_i <= 1'b0;
   end
endmodule

// file: testbench/meter_remote_command_state_bench.sv
// self-checking bench of the meter remote command state block
// assumes the checker bind and the controller model compile first
module meter_remote_command_state_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] LSN = {1'b0, mrcs_pkg::CMD_LAG, mrcs_pkg::ADDR_RST};
   localparam logic [7:0] TLK = {1'b0, mrcs_pkg::CMD_TAG, mrcs_pkg::ADDR_RST};
   logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, bus_dio_i, bus_dio_o, stat;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, dav_q, clr_q, bus_atn_i, bus_dav_i, bus_ack_i, bus_dio_oe;
   logic bus_dav_o, bus_dav_oe, bus_rxack_o, clear_init_pulse, listener_addressed_flag;
   logic meas_hold;
   logic [1:0] active_mode;
   logic [2:0] range_count, arng;
   logic [8:0] e;
   logic [8:0] expq[$];
   int num_errors = 0, total_checks = 0, clr_seen = 0;
   always #25 sys_clk = ~sys_clk;
   mrcs_top i_mrcs_top (.sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .bus_dio_i, .bus_atn_i, .bus_dav_i, .bus_ack_i, .bus_dio_o, .bus_dio_oe,
      .bus_dav_o, .bus_dav_oe, .bus_rxack_o, .clear_init_pulse, .listener_addressed_flag,
      .meas_hold, .active_mode, .range_count);
   mrcs_ctrl_model i_mrcs_ctrl_model (.sys_clk, .bus_dio_i, .bus_atn_i, .bus_dav_i, .bus_ack_i,
      .bus_rxack_o, .bus_dav_o);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task sb(input logic a, input logic [7:0] b);
      i_mrcs_ctrl_model.send_byte(a, b);
   endtask
   task ss(input string s);
      foreach (s[i]) sb(1'b0, s[i]);
   endtask
   // status, range and mode characters of one talk cycle
   task exp3(input logic [7:0] r, input logic [7:0] m);
      expq.push_back({1'b0, stat});
      expq.push_back({1'b0, r});
      expq.push_back({1'b0, m});
   endtask
   task drain;
      for (int i = 0; i < 3000 && expq.size() > 0; i++) @(posedge sys_clk);
      chk(expq.size(), 0);
   endtask
   // talk byte monitor; a byte with nothing expected never matches
   always @(posedge sys_clk) begin
      if (bus_dav_o === 1'b1 && dav_q !== 1'b1) begin
         e = expq.size() > 0 ? expq.pop_front() : 9'h100;
         chk({24'h0, bus_dio_o}, {23'h0, e});
      end
      if (clear_init_pulse === 1'b1 && clr_q !== 1'b1) clr_seen++;
      dav_q = bus_dav_o;
      clr_q = clear_init_pulse;
   end
   // the whole run takes some 800 cycles
   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      final_report;
   end
   initial begin
      void'($urandom(81252));
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(1'b0, mrcs_pkg::REG_STATE, 32'h0);
      chk(rd & 32'h007f07d7, 32'h00020104);
      stat = 8'($urandom);
      arng = 3'h1 + 3'($urandom % 5);
      apb(1'b1, mrcs_pkg::REG_MEAS, {21'h0, arng, stat});
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      repeat (8) sb(1'b0, 8'($urandom));
      sb(1'b0, {1'b0, mrcs_pkg::CMD_DCL});
      sb(1'b1, {1'b0, mrcs_pkg::CMD_SDC});
      chk(clr_seen, 0);
      sb(1'b1, LSN);
      sb(1'b1, {1'b0, mrcs_pkg::CMD_DCL});
      chk(clr_seen, 1);
      apb(1'b0, mrcs_pkg::REG_STATE, 32'h0);
      chk(rd & 32'h737f0004, 32'h00020004);
      sb(1'b1, TLK);
      repeat (80) @(posedge sys_clk);
      chk({listener_addressed_flag, meas_hold}, 2'b01);
      sb(1'b1, LSN);
      ss("B30");
      chk({meas_hold, active_mode}, 3'b100);
      exp3(8'h33, 8'h43);
      ss("C31");
      sb(1'b1, TLK);
      drain;
      chk(active_mode, 2'h2);
      sb(1'b1, {1'b0, mrcs_pkg::CMD_LAG, 5'h0e});
      ss("B31");
      repeat (40) @(posedge sys_clk);
      chk({listener_addressed_flag, meas_hold, active_mode}, 4'b0110);
      i_mrcs_ctrl_model.ack_wait = 12;
      sb(1'b1, LSN);
      exp3(8'h33, 8'h41);
      ss("A31");
      sb(1'b1, TLK);
      drain;
      chk(active_mode, 2'h0);
      i_mrcs_ctrl_model.ack_wait = 0;
      sb(1'b1, LSN);
      exp3({5'h06, arng}, 8'h44);
      ss("D91");
      sb(1'b1, TLK);
      drain;
      chk(range_count, arng);
      final_report;
   end
endmodule
